// File: hw/hpc_consts.svh
// constants for the hub port configuration register bank
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH
`define HPC_OFF_CHARGE 8'h06
`define HPC_OFF_REMOVABLE 8'h07
`define HPC_OFF_IN_USE 8'h08
`define HPC_OFF_CONFIG_TWO 8'h0a
`define HPC_RST_IN_USE 4'hf
`define HPC_RST_CFG2 8'h00
`define HPC_BIT_UNLOCK 7
`define HPC_BIT_POLARITY 5
`define HPC_BIT_CUSTOM_BC 6
`define HPC_BIT_HICUR 4
`define HPC_BIT_AUTO_MODE 1
`endif

// File: hw/hpc_pkg.sv
// types for the hub port configuration register bank
package hpc_pkg;
  typedef enum logic [2:0] {
    HPC_ST_RESET = 3'b001,
    HPC_ST_LOAD = 3'b010,
    HPC_ST_RUN = 3'b100
  } hpc_state_t;
endpackage

// File: hw/hpc_port_field.sv
// one lockable per-port field: otp-backed while locked, writable while unlocked
`timescale 1ns/10ps
module hpc_port_field #(
  parameter int WIDTH = 4,
  parameter logic [3:0] RESET_VAL = 4'h0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_unlocked,
  input wire logic i_wr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [WIDTH-1:0] i_otp,
  output logic [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] stored_r;
  logic [WIDTH-1:0] stored_nxt;

  assign stored_nxt = (i_wr && i_unlocked) ? i_wdata : stored_r;
  assign o_value = i_unlocked ? stored_r : i_otp;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stored_r <= RESET_VAL[WIDTH-1:0];
    end else begin
      stored_r <= stored_nxt;
    end
  end
endmodule // hpc_port_field

// File: hw/hpc_port_config_regs.sv
// register bank for downstream port charging, removable and in-use configuration
`timescale 1ns/10ps
`include "hpc_consts.svh"
// Contract
// - reserved upper bits read as zero
// - charge enable bit n drives port n+1
// - charge enable loads strap pins at reset release
// - loader or host may overwrite charge enable
// - locked fields read-only, reflect otp
// - unlocked fields writable by loader or host
// - unlock and removable update in one write
// - removable bit n reports port n+1
// - locked removable reads inverted otp non-removable
// - in-use bit n enables port n+1
// - in-use ignores writes unless unlocked
// - legacy-speed-only forces usb2 side in use
// - polarity bit loads polarity strap at release
// - loader writes bits, host may overwrite
module hpc_port_config_regs #(
  parameter int PORTS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [PORTS-1:0] i_power_charge_strap_pins,
  input wire logic i_polarity_strap_pin,
  input wire logic [PORTS-1:0] i_otp_non_removable,
  input wire logic [PORTS-1:0] i_otp_in_use,
  input wire logic [PORTS-1:0] i_otp_legacy_speed_only,
  input wire logic i_otp_high_current,
  input wire logic [PORTS-1:0] i_legacy_speed_only_wdata,
  input wire logic i_legacy_speed_only_wr,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [PORTS-1:0] o_charge_port_enable,
  output logic [PORTS-1:0] o_removable,
  output logic [PORTS-1:0] o_port_in_use,
  output logic [PORTS-1:0] o_usb2_in_use,
  output logic [PORTS-1:0] o_legacy_speed_only,
  output logic o_power_enable_polarity,
  output logic o_high_current_mode,
  output logic o_auto_mode_disable,
  output logic o_ready
);
  hpc_pkg::hpc_state_t state_r;
  hpc_pkg::hpc_state_t state_nxt;
  logic [PORTS-1:0] charge_r;
  logic [PORTS-1:0] charge_nxt;
  logic unlock_r;
  logic unlock_nxt;
  logic [7:0] cfg2_r;
  logic [7:0] cfg2_nxt;
  logic [PORTS-1:0] rmbl_val;
  logic [PORTS-1:0] used_val;
  logic [PORTS-1:0] legacy_val;
  logic [7:0] rdata_nxt;
  logic hicur_val;
  logic run;
  logic wr_charge;
  logic wr_rmbl;
  logic wr_used;
  logic wr_cfg2;
  logic unlock_eff;
  logic load;
  logic rd_take;
  logic hit_charge;
  logic hit_rmbl;
  logic hit_used;
  logic hit_cfg2;
  logic wr_rmbl_take;
  logic [PORTS-1:0] rmbl_field;
  logic [PORTS-1:0] usb2_use_val;

  // offset match shared by the write strobes
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  function automatic logic [7:0] pad(input logic [PORTS-1:0] v);
    pad = 8'h00;
    pad[PORTS-1:0] = v;
  endfunction

  assign run = (state_r == hpc_pkg::HPC_ST_RUN);
  assign load = (state_r == hpc_pkg::HPC_ST_LOAD);
  assign rd_take = run && i_rd;
  assign hit_charge = addr_hit(i_addr, `HPC_OFF_CHARGE);
  assign hit_rmbl = addr_hit(i_addr, `HPC_OFF_REMOVABLE);
  assign hit_used = addr_hit(i_addr, `HPC_OFF_IN_USE);
  assign hit_cfg2 = addr_hit(i_addr, `HPC_OFF_CONFIG_TWO);
  assign wr_charge = run && i_wr && hit_charge;
  assign wr_rmbl = run && i_wr && hit_rmbl;
  assign wr_used = run && i_wr && hit_used;
  assign wr_cfg2 = run && i_wr && hit_cfg2;
  // unlock written in the same access takes effect for rmbl at once
  assign unlock_eff = wr_rmbl ? i_wdata[`HPC_BIT_UNLOCK] : unlock_r;
  // a write carrying unlock=0 relocks and drops its rmbl data
  assign wr_rmbl_take = wr_rmbl && unlock_eff;

  always_comb begin
    case (state_r)
      hpc_pkg::HPC_ST_RESET: state_nxt = hpc_pkg::HPC_ST_LOAD;
      hpc_pkg::HPC_ST_LOAD: state_nxt = hpc_pkg::HPC_ST_RUN;
      hpc_pkg::HPC_ST_RUN: state_nxt = hpc_pkg::HPC_ST_RUN;
      default: state_nxt = hpc_pkg::HPC_ST_RESET;
    endcase
  end

  // straps sampled in the second cycle after reset release, while in HPC_ST_LOAD
  assign charge_nxt = load ? i_power_charge_strap_pins
    : (wr_charge ? i_wdata[PORTS-1:0] : charge_r);
  assign unlock_nxt = wr_rmbl ? i_wdata[`HPC_BIT_UNLOCK] : unlock_r;

  always_comb begin
    cfg2_nxt = cfg2_r;
    if (load) begin
      cfg2_nxt[`HPC_BIT_POLARITY] = i_polarity_strap_pin;
    end else if (wr_cfg2) begin
      cfg2_nxt = i_wdata;
      cfg2_nxt[7] = 1'b0;
      cfg2_nxt[0] = 1'b0;
      if (!i_wdata[`HPC_BIT_CUSTOM_BC]) begin
        cfg2_nxt[`HPC_BIT_HICUR] = cfg2_r[`HPC_BIT_HICUR];
      end
    end
  end

  // removable storage holds the active-high removable value
  // storage view only; the lock view is chosen below from the lock register
  hpc_port_field #(.WIDTH(PORTS), .RESET_VAL(4'h0)) u_rmbl (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_unlocked(1'b1),
    .i_wr(wr_rmbl_take),
    .i_wdata(i_wdata[PORTS-1:0]),
    .i_otp(~i_otp_non_removable),
    .o_value(rmbl_field)
  );
  // view follows the stored lock bit, never the access in flight
  assign rmbl_val = unlock_r ? rmbl_field : ~i_otp_non_removable;

  hpc_port_field #(.WIDTH(PORTS), .RESET_VAL(`HPC_RST_IN_USE)) u_used (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_unlocked(unlock_r),
    .i_wr(wr_used),
    .i_wdata(i_wdata[PORTS-1:0]),
    .i_otp(i_otp_in_use),
    .o_value(used_val)
  );

  hpc_port_field #(.WIDTH(PORTS), .RESET_VAL(4'h0)) u_legacy (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_unlocked(unlock_r),
    .i_wr(run && i_legacy_speed_only_wr),
    .i_wdata(i_legacy_speed_only_wdata),
    .i_otp(i_otp_legacy_speed_only),
    .o_value(legacy_val)
  );

  assign hicur_val = cfg2_r[`HPC_BIT_CUSTOM_BC] ? cfg2_r[`HPC_BIT_HICUR] : i_otp_high_current;
  assign usb2_use_val = used_val | legacy_val;

  always_comb begin
    case (i_addr)
      `HPC_OFF_CHARGE: rdata_nxt = pad(charge_r);
      `HPC_OFF_REMOVABLE: rdata_nxt = pad(rmbl_val) | {unlock_r, 7'h00};
      `HPC_OFF_IN_USE: rdata_nxt = pad(used_val);
      `HPC_OFF_CONFIG_TWO: rdata_nxt = {cfg2_r[7:5], hicur_val, cfg2_r[3:0]};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= hpc_pkg::HPC_ST_RESET;
      charge_r <= '0;
      unlock_r <= 1'b0;
      cfg2_r <= `HPC_RST_CFG2;
    end else begin
      state_r <= state_nxt;
      charge_r <= charge_nxt;
      unlock_r <= unlock_nxt;
      cfg2_r <= cfg2_nxt;
    end
  end

  // read port: data holds between reads, valid pulses one cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      o_rdata <= rd_take ? rdata_nxt : o_rdata;
      o_rvalid <= rd_take;
      o_ready <= run;
    end
  end

  // field outputs trail their registers by one cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_charge_port_enable <= '0;
      o_removable <= '0;
      o_port_in_use <= '0;
      o_usb2_in_use <= '0;
      o_legacy_speed_only <= '0;
      o_power_enable_polarity <= 1'b0;
      o_high_current_mode <= 1'b0;
      o_auto_mode_disable <= 1'b0;
    end else begin
      o_charge_port_enable <= charge_r;
      o_removable <= rmbl_val;
      o_port_in_use <= used_val;
      o_usb2_in_use <= usb2_use_val;
      o_legacy_speed_only <= legacy_val;
      o_power_enable_polarity <= cfg2_r[`HPC_BIT_POLARITY];
      o_high_current_mode <= hicur_val;
      o_auto_mode_disable <= cfg2_r[`HPC_BIT_AUTO_MODE];
    end
  end
endmodule // hpc_port_config_regs

// File: bench/hpc_port_config_regs_checker.sv
// register port assertions
`timescale 1ns/10ps
module hpc_port_config_regs_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [3:0] i_otp_non_removable,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence rd_s(a); i_rd && o_ready && i_addr == a; endsequence
  rd_answer_a: assert property (i_rd && o_ready |=> o_rvalid) else $error("no ack");
  rd_cause_a: assert property (o_rvalid |-> $past(i_rd && o_ready))
    else $error("stray ack");
  chg_rsvd_a: assert property (rd_s(8'h06) |=> o_rdata[7:4] == 4'h0)
    else $error("charge reserved");
  rmbl_rsvd_a: assert property (rd_s(8'h07) |=> o_rdata[6:4] == 3'h0)
    else $error("removable reserved");
  use_rsvd_a: assert property (rd_s(8'h08) |=> o_rdata[7:4] == 4'h0)
    else $error("in-use reserved");
  locked_rmbl_a: assert property (rd_s(8'h07) ##1 !o_rdata[7] |->
    o_rdata[3:0] == ~$past(i_otp_non_removable)) else $error("locked removable");
  unmapped_zero_a: assert property (i_rd && o_ready &&
    !(i_addr inside {8'h06, 8'h07, 8'h08, 8'h0a}) |=> o_rdata == 8'h00) else $error("unmapped");
  ready_hold_a: assert property (o_ready |=> o_ready) else $error("ready dropped");
endmodule // hpc_port_config_regs_checker

// File: bench/hpc_host.sv
// smbus host stand-in
`timescale 1ns/10ps
module hpc_host (
  input wire logic i_clk,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {o_wr, o_rd, o_addr, o_wdata} <= {w, !w, a, d};
    @(posedge i_clk);
    {o_wr, o_rd, o_addr, o_wdata} <= {2'b00, ~a, ~d};
  endtask
endmodule // hpc_host

// File: bench/hpc_port_config_regs_test.sv
// register bank bench
`timescale 1ns/10ps
bind hpc_port_config_regs hpc_port_config_regs_checker u_chk (.i_clk, .i_rst, .i_rd, .i_addr,
  .i_otp_non_removable, .o_rdata, .o_rvalid, .o_ready);
module hpc_port_config_regs_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr, i_rd, i_legacy_speed_only_wr, o_rvalid, o_power_enable_polarity, o_ready;
  logic o_high_current_mode, o_auto_mode_disable;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [3:0] i_otp_legacy_speed_only, i_legacy_speed_only_wdata, o_charge_port_enable;
  logic [3:0] o_removable, o_port_in_use, o_usb2_in_use, o_legacy_speed_only;
  int err_total = 0;
  int cmp_count = 0;
  always #10 i_clk = ~i_clk;
  hpc_host u_hpc_host (.i_clk, .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  hpc_port_config_regs u_hpc_port_config_regs (.*, .i_power_charge_strap_pins(4'h9),
    .i_polarity_strap_pin(1'b1), .i_otp_non_removable(4'h3), .i_otp_in_use(4'hc),
    .i_otp_high_current(1'b0));
  task automatic ck(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rk(input logic [7:0] a, input logic [7:0] e);
    u_hpc_host.req(1'b0, a, 8'h00);
    @(negedge i_clk);
    ck("rdata", e, o_rdata);
  endtask
  task automatic t_locked;
    rk(8'h06, 8'h09);
    ck("charge out", 8'h09, {4'h0, o_charge_port_enable});
    rk(8'h0a, 8'h20);
    ck("polarity out", 8'h01, {7'h00, o_power_enable_polarity});
    u_hpc_host.req(1'b1, 8'h08, 8'h05);
    rk(8'h08, 8'h0c);
    rk(8'h07, 8'h0c);
    ck("removable out", 8'h0c, {4'h0, o_removable});
    ck("in-use out", 8'h0c, {4'h0, o_port_in_use});
    ck("legacy out", 8'h02, {4'h0, o_legacy_speed_only});
    ck("usb2 locked", 8'h0e, {4'h0, o_usb2_in_use});
    rk(8'h09, 8'h00);
  endtask
  task automatic t_unlock;
    u_hpc_host.req(1'b1, 8'h06, 8'hf6);
    u_hpc_host.req(1'b1, 8'h07, 8'hf5);
    u_hpc_host.req(1'b1, 8'h08, 8'hf6);
    rk(8'h06, 8'h06);
    rk(8'h07, 8'h85);
    rk(8'h08, 8'h06);
    ck("charge out", 8'h06, {4'h0, o_charge_port_enable});
    ck("removable out", 8'h05, {4'h0, o_removable});
    ck("in-use out", 8'h06, {4'h0, o_port_in_use});
    @(posedge i_clk);
    {i_legacy_speed_only_wr, i_legacy_speed_only_wdata} <= 5'h11;
    @(posedge i_clk);
    i_legacy_speed_only_wr <= 1'b0;
    repeat (3) @(negedge i_clk);
    ck("legacy out", 8'h01, {4'h0, o_legacy_speed_only});
    ck("usb2 use", 8'h07, {4'h0, o_usb2_in_use});
  endtask
  task automatic t_relock;
    u_hpc_host.req(1'b1, 8'h07, 8'h0a);
    rk(8'h07, 8'h0c);
    rk(8'h08, 8'h0c);
    ck("removable relocked", 8'h0c, {4'h0, o_removable});
    ck("legacy relocked", 8'h02, {4'h0, o_legacy_speed_only});
    ck("usb2 relocked", 8'h0e, {4'h0, o_usb2_in_use});
  endtask
  task automatic t_cfg2;
    u_hpc_host.req(1'b1, 8'h0a, 8'h5f);
    rk(8'h0a, 8'h5e);
    ck("hicur out", 8'h01, {7'h00, o_high_current_mode});
    ck("auto off out", 8'h01, {7'h00, o_auto_mode_disable});
    ck("polarity written", 8'h00, {7'h00, o_power_enable_polarity});
    u_hpc_host.req(1'b1, 8'h0a, 8'h20);
    rk(8'h0a, 8'h20);
    ck("hicur otp", 8'h00, {7'h00, o_high_current_mode});
    ck("auto on out", 8'h00, {7'h00, o_auto_mode_disable});
    ck("polarity back", 8'h01, {7'h00, o_power_enable_polarity});
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (500) @(posedge i_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    {i_legacy_speed_only_wr, i_legacy_speed_only_wdata, i_otp_legacy_speed_only} <= 9'h002;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (5) @(posedge i_clk);
    t_locked();
    t_unlock();
    t_relock();
    t_cfg2();
    end_of_test();
  end
endmodule // hpc_port_config_regs_test
